// [hdl/umaf_pkg.sv]
package umaf_pkg;
  // ****************************************************
  // register map and reset values
  // ****************************************************
  localparam logic [7:0] OWN_ADDR_OFS = 8'ha9;
  localparam logic [7:0] ADDR_MASK_OFS = 8'hb9;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] ADDR_MASK_RST = 8'h00;

  // ****************************************************
  // serial port modes
  // ****************************************************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_TEN = 2'h1;
  localparam logic [1:0] MODE_ELEVEN_A = 2'h2;
  localparam logic [1:0] MODE_ELEVEN_B = 2'h3;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [7:0] data;
    logic bit9;
  } umaf_frame_s;

  typedef struct packed {
    logic [7:0] own_addr;
    logic [7:0] addr_mask;
  } umaf_addr_s;

  typedef struct packed {
    umaf_addr_s addr;
    logic [7:0] serial_buffer;
    logic rx_ninth_bit;
    logic rx_done_flag;
  } umaf_state_s;
endpackage : umaf_pkg

// [hdl/umaf_match.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// address comparator: given and broadcast matches
// ****************************************************
module umaf_match #(
  parameter int W = 8
) (
  input wire logic [W-1:0] rx_byte,
  input wire logic [W-1:0] own_addr,
  input wire logic [W-1:0] addr_mask,
  output logic given_hit,
  output logic bcast_hit
);
  logic [W-1:0] bcast;

  // masked compare and broadcast compare
  always_comb begin
    bcast = own_addr | addr_mask;
    given_hit = ((rx_byte ^ own_addr) & addr_mask) == '0;
    bcast_hit = (rx_byte & bcast) == bcast;
  end
endmodule // umaf_match
`default_nettype wire

// [hdl/umaf_filter.sv]
// Behaviour
// - filter in ten- and eleven-bit modes; shift mode ignores
// - store ninth received bit after nine bits
// - enable set: only ninth-bit-one frames flag
// - master sends address ninth=1, data ninth=0
// - enable set, ten-bit mode: flag only with valid stop
// - enable set: flag only on address match
// - ten-bit mode: stop bit marks address frame
// - given address is own AND mask
// - broadcast address is own OR mask
// - reset clears own address and mask
// - own address register eight bits at a9
// - mask register eight bits at b9
// - load only if flag clear and condition met
`timescale 1ns/100ps
`default_nettype none
module umaf_filter (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] serial_mode,
  input wire logic multiproc_enable,
  input wire logic frame_valid,
  input wire umaf_pkg::umaf_frame_s frame_in,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic rx_done_clr,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] serial_buffer,
  output logic rx_ninth_bit,
  output logic rx_done_flag
);
  umaf_pkg::umaf_state_s st_ff;
  umaf_pkg::umaf_state_s nxt_st;
  logic given_hit;
  logic bcast_hit;
  logic eleven;
  logic ten;
  logic marker;
  logic cond_ok;
  logic accept;

  // ****************************************************
  // register address decode
  // ****************************************************
  // one decoder shared by the write path, read mux and read checks
  function automatic logic reg_sel(input logic [7:0] a,
    input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************************
  // address comparator
  // ****************************************************
  umaf_match #(.W(8)) u_match (
    .rx_byte(frame_in.data),
    .own_addr(st_ff.addr.own_addr),
    .addr_mask(st_ff.addr.addr_mask),
    .given_hit(given_hit),
    .bcast_hit(bcast_hit)
  );

  // ****************************************************
  // acceptance decision
  // ****************************************************
  // in ten-bit mode the stop bit arrives in bit9
  always_comb begin
    eleven = (serial_mode == umaf_pkg::MODE_ELEVEN_A) ||
      (serial_mode == umaf_pkg::MODE_ELEVEN_B);
    ten = serial_mode == umaf_pkg::MODE_TEN;
    marker = frame_in.bit9;
    if (!multiproc_enable || !(eleven || ten)) begin
      cond_ok = 1'b1;
    end else begin
      cond_ok = marker && (given_hit || bcast_hit);
    end
    accept = frame_valid && !st_ff.rx_done_flag && cond_ok;
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    nxt_st = st_ff;
    if (sfr_wr && reg_sel(sfr_addr, umaf_pkg::OWN_ADDR_OFS)) begin
      nxt_st.addr.own_addr = sfr_wdata;
    end
    if (sfr_wr && reg_sel(sfr_addr, umaf_pkg::ADDR_MASK_OFS)) begin
      nxt_st.addr.addr_mask = sfr_wdata;
    end
    if (rx_done_clr) begin
      nxt_st.rx_done_flag = 1'b0;
    end
    // set wins over clear
    if (accept) begin
      nxt_st.serial_buffer = frame_in.data;
      nxt_st.rx_ninth_bit = frame_in.bit9;
      nxt_st.rx_done_flag = 1'b1;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff.addr.own_addr <= umaf_pkg::OWN_ADDR_RST;
      st_ff.addr.addr_mask <= umaf_pkg::ADDR_MASK_RST;
      st_ff.serial_buffer <= 8'h00;
      st_ff.rx_ninth_bit <= 1'b0;
      st_ff.rx_done_flag <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // read mux, combinational
  always_comb begin
    sfr_hit = reg_sel(sfr_addr, umaf_pkg::OWN_ADDR_OFS) ||
      reg_sel(sfr_addr, umaf_pkg::ADDR_MASK_OFS);
    sfr_rdata = 8'h00; // other addresses read zero
    if (sfr_rd && reg_sel(sfr_addr, umaf_pkg::OWN_ADDR_OFS)) begin
      sfr_rdata = st_ff.addr.own_addr;
    end else if (sfr_rd && reg_sel(sfr_addr, umaf_pkg::ADDR_MASK_OFS)) begin
      sfr_rdata = st_ff.addr.addr_mask;
    end
  end

  assign serial_buffer = st_ff.serial_buffer;
  assign rx_ninth_bit = st_ff.rx_ninth_bit;
  assign rx_done_flag = st_ff.rx_done_flag;

  // ****************************************************
  // checks
  // ****************************************************
  // shift mode ignores the enable bit
  chk_shift_unfiltered: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && serial_mode == umaf_pkg::MODE_SHIFT && !rx_done_flag
      |=> rx_done_flag)
    else $error("shift mode frame not accepted");
  // ninth bit follows every accepted frame
  chk_ninth_stored: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    accept |=> rx_ninth_bit == $past(frame_in.bit9))
    else $error("ninth bit not stored");
  // data frames stay silent while filtering
  chk_data_frame_dropped: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && eleven && !frame_in.bit9 &&
      !rx_done_flag && !rx_done_clr |=> !rx_done_flag)
    else $error("data frame raised flag");
  // enable low: every frame into a free buffer lands
  chk_filter_off: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && !multiproc_enable && !rx_done_flag |=> rx_done_flag &&
      serial_buffer == $past(frame_in.data))
    else $error("unfiltered frame not accepted");
  // ten-bit mode: a bad stop bit is dropped
  chk_bad_stop: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && ten && !frame_in.bit9 &&
      !rx_done_flag && !rx_done_clr |=> !rx_done_flag)
    else $error("invalid stop raised flag");
  // ten-bit mode: good stop plus match is taken
  chk_ten_accept: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && ten && frame_in.bit9 &&
      (given_hit || bcast_hit) && !rx_done_flag |=> rx_done_flag)
    else $error("ten-bit address frame not accepted");
  // no match: buffer and flag untouched
  chk_addr_mismatch: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && (eleven || ten) && !given_hit &&
      !bcast_hit && !rx_done_flag |=> !rx_done_flag &&
      $stable(serial_buffer))
    else $error("mismatched address loaded");
  // given match loads the address frame
  chk_given_accept: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && eleven && frame_in.bit9 &&
      given_hit && !rx_done_flag |=> rx_done_flag &&
      serial_buffer == $past(frame_in.data))
    else $error("given address frame not loaded");
  // broadcast match loads the address frame
  chk_bcast_accept: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && multiproc_enable && eleven && frame_in.bit9 &&
      bcast_hit && !rx_done_flag |=> rx_done_flag &&
      serial_buffer == $past(frame_in.data))
    else $error("broadcast address frame not loaded");
  // comparator against an independent form, while a frame is present
  chk_given_match: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid |-> given_hit == ((frame_in.data & st_ff.addr.addr_mask) ==
      (st_ff.addr.own_addr & st_ff.addr.addr_mask)))
    else $error("given match wrong");
  chk_bcast_match: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid |-> bcast_hit ==
      (&(frame_in.data | ~(st_ff.addr.own_addr | st_ff.addr.addr_mask))))
    else $error("broadcast match wrong");
  // reset clears both address registers
  chk_reset_clear: assert property (
    @(posedge sys_clk)
    !nrst |=> st_ff.addr.own_addr == umaf_pkg::OWN_ADDR_RST &&
      st_ff.addr.addr_mask == umaf_pkg::ADDR_MASK_RST)
    else $error("address regs not cleared");
  // register writes land one cycle later
  chk_own_write: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sfr_wr && sfr_addr == umaf_pkg::OWN_ADDR_OFS |=>
      st_ff.addr.own_addr == $past(sfr_wdata))
    else $error("own address write lost");
  chk_mask_write: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sfr_wr && sfr_addr == umaf_pkg::ADDR_MASK_OFS |=>
      st_ff.addr.addr_mask == $past(sfr_wdata))
    else $error("mask write lost");
  // reads of unknown addresses return zero
  chk_read_refused: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sfr_rd && !sfr_hit |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_own_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sfr_rd && reg_sel(sfr_addr, umaf_pkg::OWN_ADDR_OFS) |->
      sfr_rdata == st_ff.addr.own_addr)
    else $error("own address read wrong");
  // full buffer keeps its byte and flag
  chk_full_hold: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    rx_done_flag && !rx_done_clr ##1 frame_valid |=> $stable(serial_buffer))
    else $error("buffer overwritten while flag set");
  chk_flag_hold: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    rx_done_flag && !rx_done_clr |=> rx_done_flag)
    else $error("flag dropped without clear");
  chk_flag_clear: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    rx_done_clr && !accept |=> !rx_done_flag)
    else $error("flag clear lost");
endmodule // umaf_filter
`default_nettype wire

// [dv/umaf_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// remote master: one frame per request, held one cycle
// ****************************************************
module umaf_master_model (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic is_addr,
  input wire logic [7:0] byte_d,
  output var logic frame_valid,
  output var umaf_pkg::umaf_frame_s frame_in
);
  // address frames carry ninth bit 1, data frames 0
  always_ff @(posedge sys_clk) begin
    frame_valid <= req;
    frame_in <= req ? {byte_d, is_addr} : ~frame_in;
  end
endmodule // umaf_master_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  logic sys_clk, nrst, sfr_wr, sfr_rd, rx_done_clr, req, is_addr;
  logic multiproc_enable, frame_valid, sfr_hit, rx_ninth_bit, rx_done_flag;
  logic e_flag, e_b9;
  logic [1:0] serial_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, serial_buffer, byte_d;
  logic [7:0] own, msk, lf, e_buf;
  umaf_pkg::umaf_frame_s frame_in;
  int n_fail, checked;
  umaf_filter umaf_filter_inst (.sys_clk, .nrst, .serial_mode,
    .multiproc_enable, .frame_valid, .frame_in, .sfr_wr, .sfr_rd, .sfr_addr,
    .sfr_wdata, .rx_done_clr, .sfr_rdata, .sfr_hit, .serial_buffer,
    .rx_ninth_bit, .rx_done_flag);
  umaf_master_model umaf_master_model_inst (.sys_clk, .req, .is_addr,
    .byte_d, .frame_valid, .frame_in);
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // frame accepted by a clear flag: filter off, shift mode, or marker+match
  function automatic logic acc(input logic [1:0] m, input logic en, b,
                               input logic [7:0] d, o, k);
    return !en || m == umaf_pkg::MODE_SHIFT ||
      (b && ((((d ^ o) & k) == 8'h00) || ((d & (o | k)) == (o | k))));
  endfunction
  // write one register, then let an edge pass
  task automatic wr(input logic [7:0] a, d);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // read held over one edge, answer taken at that edge
  task automatic rd(input logic [7:0] a, e, input logic h);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge sys_clk);
    `CHK("sfr_rdata", e, sfr_rdata)
    `CHK("sfr_hit", h, sfr_hit)
    #1 sfr_rd = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // random frames with a broadcast corner every eighth frame
  task automatic frames(input int n);
    for (int i = 0; i < n; i++) begin
      lf = lfsr(lf);
      serial_mode = lf[1:0];
      multiproc_enable = lf[2] | lf[3];
      is_addr = lf[4] | lf[5];
      byte_d = lf[6] ? own ^ {5'h00, lf[2:0]} : lfsr(lf);
      if (i % 8 == 3) begin
        multiproc_enable = 1'b1;
        is_addr = 1'b1;
        byte_d = own | msk;
      end
      if (lf[7]) begin
        rx_done_clr = 1'b1;
        e_flag = 1'b0;
        @(posedge sys_clk);
        #1 rx_done_clr = 1'b0;
      end
      req = 1'b1;
      @(posedge sys_clk);
      #1 req = 1'b0;
      @(posedge sys_clk);
      #1;
      if (!e_flag && acc(serial_mode, multiproc_enable, is_addr, byte_d,
                         own, msk)) begin
        e_flag = 1'b1;
        e_buf = byte_d;
        e_b9 = is_addr;
      end
      `CHK("rx_done_flag", e_flag, rx_done_flag)
      `CHK("serial_buffer", e_buf, serial_buffer)
      `CHK("rx_ninth_bit", e_b9, rx_ninth_bit)
    end
  endtask
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************************
  // clock, watchdog, sequence
  // ****************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // watchdog: the tests need at most 1048 cycles, this allows 10000
  initial begin
    #50000;
    n_fail++;
    results();
  end
  initial begin
    {nrst, sfr_wr, sfr_rd, rx_done_clr, req, is_addr, multiproc_enable} = '0;
    serial_mode = 2'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    byte_d = 8'h00;
    lf = 8'h37; // seed 55
    n_fail = 0;
    checked = 0;
    e_flag = 1'b0;
    e_buf = 8'h00;
    e_b9 = 1'b0;
    own = 8'h00;
    msk = 8'h00;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rd(umaf_pkg::OWN_ADDR_OFS, 8'h00, 1'b1);
    rd(umaf_pkg::ADDR_MASK_OFS, 8'h00, 1'b1);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00, 1'b0);
    own = 8'hc0;
    msk = 8'hfd;
    wr(umaf_pkg::OWN_ADDR_OFS, own);
    wr(umaf_pkg::ADDR_MASK_OFS, msk);
    rd(umaf_pkg::OWN_ADDR_OFS, own, 1'b1);
    rd(umaf_pkg::ADDR_MASK_OFS, msk, 1'b1);
    $display("test regs done");
    frames(150);
    own = 8'he0;
    msk = 8'hfa;
    wr(umaf_pkg::OWN_ADDR_OFS, own);
    wr(umaf_pkg::ADDR_MASK_OFS, msk);
    frames(150);
    $display("test frames done");
    // mid-run reset: registers and flag return to zero
    nrst = 1'b0;
    @(posedge sys_clk);
    #1 nrst = 1'b1;
    own = 8'h00;
    msk = 8'h00;
    e_flag = 1'b0;
    e_buf = 8'h00;
    e_b9 = 1'b0;
    `CHK("rx_done_flag", e_flag, rx_done_flag)
    `CHK("serial_buffer", e_buf, serial_buffer)
    rd(umaf_pkg::OWN_ADDR_OFS, 8'h00, 1'b1);
    rd(umaf_pkg::ADDR_MASK_OFS, 8'h00, 1'b1);
    frames(40);
    $display("test reset done");
    results();
  end
endmodule // tb_top
`default_nettype wire
